/* verilog/ssp_pkg.sv */
// constants, types and helpers shared by the spi stream port
// assumes one 25 mhz core clock; no software registers
//
// Operation
// - spi mode only if strap low at startup
// - timepulse function enabled forces spi mode off
// - slave only, mode 3, clock idles high
// - sample on rising edge, shift on falling
// - chip select is a low level, not edge
// - no data ready means zero bytes out
// - select toggle resets the shift register
// - data ready rises when buffer holds data; here only once it holds more than one byte
// - one to four zero bytes may lead
// - data ready may fall before last bytes
// - no idle filler code; parse stream instead
// - transmit buffer holds 4096 bytes
// - overflow drops whole buffer, then zeros
// - next queued packet ends overflow state
// - link rate up to 3, paced 5 mbs
// - packets follow the binary serial framing
// - packets start with byte ff
// - packets end with fe; new start restarts
package ssp_pkg;

  localparam int              BYTE_W         = 8;
  localparam int              BUF_DEPTH      = 4096;
  localparam int              ADDR_W         = 12;
  localparam int              CNT_W          = 13;
  localparam int              BIT_CNT_W      = 3;
  localparam logic [CNT_W-1:0] BUF_FULL      = 13'h1000;
  localparam logic [CNT_W-1:0] RDY_TAIL      = 13'h0001;
  localparam logic [7:0]      START_BYTE     = 8'hff;
  localparam logic [7:0]      END_BYTE       = 8'hfe;
  localparam logic [7:0]      ZERO_BYTE      = 8'h00;
  localparam logic [2:0]      LAST_BIT       = 3'h7;
  localparam logic [2:0]      FIRST_BIT      = 3'h0;
  localparam int              SPI_MODE_NUM   = 3;
  localparam logic            SCLK_IDLE      = 1'b1;
  localparam int              CLK_HZ         = 25000000;
  localparam int              MAX_BPS        = 3000000;
  localparam int              PACED_BPS      = 5000000;
  localparam int              BIT_CYC_PACED  = CLK_HZ / PACED_BPS;
  localparam logic [1:0]      STRAP_WAIT     = 2'h3;
  localparam int              SYNC_W         = 4;
  // sync lanes: {strap, mosi, cs_n, sclk}
  localparam logic [3:0]      SYNC_RST       = 4'hb;
  localparam int              LN_SCLK        = 0;
  localparam int              LN_CS          = 1;
  localparam int              LN_MOSI        = 2;
  localparam int              LN_STRAP       = 3;

  typedef enum logic { SSP_WR_PASS, SSP_WR_HUNT } ssp_wr_e;

  function automatic logic ssp_is_start(input logic [7:0] b);
    ssp_is_start = (b == START_BYTE);
  endfunction : ssp_is_start

endpackage : ssp_pkg

/* verilog/ssp_sync.sv */
// two-flop synchronisers for the pins of the spi stream port
// assumes asynchronous pins and a gated core clock
`timescale 1ns/10ps
module ssp_sync
  import ssp_pkg::*;
#(
  parameter int             W   = SYNC_W,
  parameter logic [W-1:0]   RST = SYNC_RST
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_ff[i] <= RST[i];
          q[i]       <= RST[i];
        end else if (clk_en) begin
          meta_ff[i] <= d[i];
          q[i]       <= meta_ff[i];
        end
      end
    end
  endgenerate

endmodule : ssp_sync

/* verilog/ssp_buf_mem.sv */
// byte store of the transmit buffer, registered read data
// assumes caller never reads and writes one address in a cycle
`timescale 1ns/10ps
module ssp_buf_mem
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic              re,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata_ff
);

  logic [7:0] mem [BUF_DEPTH];

  // storage of 4096 bytes
  always_ff @(posedge clk) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= ZERO_BYTE;
    end else if (clk_en && re) begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule : ssp_buf_mem

/* verilog/ssp_stream_port.sv */
// spi slave stream port: buffer, shifter, data ready, strap
// assumes pins asynchronous; writer logic on clk; sclk << clk/4
`timescale 1ns/10ps
module ssp_stream_port
  import ssp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       shared_strap_timepulse_pin,
  input  wire logic       timepulse_func_en,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            data_ready_out,
  output logic            spi_mode_en,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            overflow_evt
);

  // synchronised pins
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic              sclk_s;
  logic              cs_n_s;
  logic              mosi_s;
  logic              port_select_strap_n;

  assign pin_raw[LN_SCLK]  = sclk;
  assign pin_raw[LN_CS]    = cs_n;
  assign pin_raw[LN_MOSI]  = mosi;
  assign pin_raw[LN_STRAP] = shared_strap_timepulse_pin;

  ssp_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .clk_en (clk_en),
    .d      (pin_raw),
    .q      (pin_s)
  );

  assign sclk_s              = pin_s[LN_SCLK];
  assign cs_n_s              = pin_s[LN_CS];
  assign mosi_s              = pin_s[LN_MOSI];
  assign port_select_strap_n = pin_s[LN_STRAP];

  // state
  logic [1:0]        strap_cnt_ff;
  logic              strap_done_ff;
  logic              spi_sel_ff;
  logic              sclk_d_ff;
  logic [2:0]        bit_cnt_ff;
  logic [7:0]        tx_sh_ff;
  logic              miso_ff;
  logic [7:0]        rx_sh_ff;
  logic [7:0]        rx_data_ff;
  logic              rx_valid_ff;
  logic [7:0]        hold_ff;
  logic              hold_vld_ff;
  logic              rd_pend_ff;
  logic [ADDR_W-1:0] wr_ptr_ff;
  logic [ADDR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0]  count_ff;
  logic              ovf_ff;
  logic              rdy_ff;
  ssp_wr_e           wr_st_ff;
  logic [7:0]        mem_rdata;

  // decode
  logic              link_on;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              take_byte;
  logic              wr_go;
  logic              buf_full;
  logic              ovf_now;
  logic              mem_we;
  logic              rd_go;
  logic              rdy_want;
  logic [7:0]        next_out;
  logic [CNT_W-1:0]  nxt_count;
  ssp_wr_e           nxt_wr_st;

  // timepulse use overrides the strap at any time
  assign spi_mode_en = spi_sel_ff & ~timepulse_func_en;
  // select is a plain low level
  assign link_on     = spi_mode_en & ~cs_n_s;
  // mode 3: idle high, leading edge falls
  assign sclk_rise   = link_on & sclk_s & ~sclk_d_ff;
  assign sclk_fall   = link_on & ~sclk_s & sclk_d_ff;
  assign take_byte   = sclk_fall & (bit_cnt_ff == FIRST_BIT);
  // empty hold means a zero character
  assign next_out    = hold_vld_ff ? hold_ff : ZERO_BYTE;

  // writer side: after overflow wait for a packet start
  assign wr_go    = spi_mode_en & wr_valid &
                    ((wr_st_ff == SSP_WR_PASS) ||
                     ssp_is_start(wr_data));
  assign buf_full = (count_ff == BUF_FULL);
  assign ovf_now  = wr_go & buf_full;
  assign mem_we   = wr_go & ~buf_full;
  // prefetch into hold only while selected
  assign rd_go    = link_on & ~hold_vld_ff & ~rd_pend_ff &
                    (count_ff != '0) & ~ovf_now;
  assign nxt_count = ovf_now ? '0 :
                     CNT_W'(count_ff + CNT_W'(mem_we) - CNT_W'(rd_go));
  assign nxt_wr_st = ovf_now ? SSP_WR_HUNT :
                     (wr_go ? SSP_WR_PASS : wr_st_ff);
  // drops early, stays up after overflow with nothing behind it
  assign rdy_want = spi_mode_en &
                    ((count_ff > RDY_TAIL) || ovf_ff);

  assign miso           = miso_ff;
  assign data_ready_out = rdy_ff;
  assign rx_valid       = rx_valid_ff;
  assign rx_data        = rx_data_ff;
  assign overflow_evt   = ovf_now;

  ssp_buf_mem u_mem (
    .clk      (clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .we       (mem_we),
    .waddr    (wr_ptr_ff),
    .wdata    (wr_data),
    .re       (rd_go),
    .raddr    (rd_ptr_ff),
    .rdata_ff (mem_rdata)
  );

  // strap caught once, after the synchroniser settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt_ff  <= '0;
      strap_done_ff <= 1'b0;
      spi_sel_ff    <= 1'b0;
    end else if (clk_en && !strap_done_ff) begin
      strap_cnt_ff <= 2'(strap_cnt_ff + 2'h1);
      if (strap_cnt_ff == STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        spi_sel_ff    <= ~port_select_strap_n;
      end
    end
  end

  // clock edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_ff <= SCLK_IDLE;
    end else if (clk_en) begin
      sclk_d_ff <= sclk_s;
    end
  end

  // shift engine, cleared whenever select is high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_ff <= FIRST_BIT;
      tx_sh_ff   <= ZERO_BYTE;
      miso_ff    <= 1'b0;
      rx_sh_ff   <= ZERO_BYTE;
    end else if (clk_en) begin
      if (!link_on) begin
        bit_cnt_ff <= FIRST_BIT;
        tx_sh_ff   <= ZERO_BYTE;
        miso_ff    <= 1'b0;
        rx_sh_ff   <= ZERO_BYTE;
      end else if (take_byte) begin
        miso_ff  <= next_out[7];
        tx_sh_ff <= {next_out[6:0], 1'b0};
      end else if (sclk_fall) begin
        miso_ff  <= tx_sh_ff[7];
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end else if (sclk_rise) begin
        rx_sh_ff   <= {rx_sh_ff[6:0], mosi_s};
        bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
      end
    end
  end

  // received character, one-cycle strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= ZERO_BYTE;
    end else if (clk_en) begin
      rx_valid_ff <= sclk_rise && (bit_cnt_ff == LAST_BIT);
      if (sclk_rise && (bit_cnt_ff == LAST_BIT)) begin
        rx_data_ff <= {rx_sh_ff[6:0], mosi_s};
      end
    end
  end

  // buffer pointers and fill level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      wr_st_ff  <= SSP_WR_PASS;
    end else if (clk_en) begin
      count_ff <= nxt_count;
      wr_st_ff <= nxt_wr_st;
      if (ovf_now) begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
      end else begin
        if (mem_we) begin
          wr_ptr_ff <= ADDR_W'(wr_ptr_ff + 1'b1);
        end
        if (rd_go) begin
          rd_ptr_ff <= ADDR_W'(rd_ptr_ff + 1'b1);
        end
      end
    end
  end

  // hold register in front of the shifter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_ff     <= ZERO_BYTE;
      hold_vld_ff <= 1'b0;
      rd_pend_ff  <= 1'b0;
    end else if (clk_en) begin
      if (ovf_now) begin
        hold_vld_ff <= 1'b0;
        rd_pend_ff  <= 1'b0;
      end else begin
        rd_pend_ff <= rd_go;
        if (rd_pend_ff) begin
          hold_ff     <= mem_rdata;
          hold_vld_ff <= 1'b1;
        end else if (take_byte) begin
          hold_vld_ff <= 1'b0;
        end
      end
    end
  end

  // overflow marker; a new overflow wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end else if (clk_en) begin
      rdy_ff <= rdy_want;
      if (ovf_now) begin
        ovf_ff <= 1'b1;
      end else if (wr_go && ssp_is_start(wr_data)) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ovf;
    clk_en && ovf_now;
  endsequence

  sequence s_restart;
    clk_en && wr_go && ssp_is_start(wr_data) && !buf_full;
  endsequence

  sequence s_load_empty;
    clk_en && take_byte && !hold_vld_ff;
  endsequence

  a_strap_latch: assert property (
    clk_en && !strap_done_ff && strap_cnt_ff == STRAP_WAIT
    |=> spi_sel_ff == !$past(port_select_strap_n))
    else $error("strap not latched");

  a_timepulse_off: assert property (
    timepulse_func_en |-> !spi_mode_en ##1 (!rdy_ff || !clk_en))
    else $error("spi mode active with timepulse");

  a_zero_fill: assert property (
    s_load_empty |=> !miso_ff && tx_sh_ff == ZERO_BYTE)
    else $error("nonzero fill");

  a_shift_reset: assert property (
    clk_en && cs_n_s |=> bit_cnt_ff == FIRST_BIT && !miso_ff)
    else $error("shift register kept while deselected");

  a_miso_edge: assert property (
    $changed(miso_ff) |-> $past(sclk_fall || !link_on))
    else $error("miso moved off falling edge");

  a_rx_strobe: assert property (
    clk_en && sclk_rise && bit_cnt_ff == LAST_BIT
    |=> rx_valid_ff ##1 (!rx_valid_ff || !clk_en))
    else $error("character strobe wrong");

  a_no_read_idle: assert property (
    cs_n_s |-> !rd_go)
    else $error("buffer read while deselected");

  a_ready_level: assert property (
    clk_en && spi_mode_en && count_ff > RDY_TAIL |=> rdy_ff)
    else $error("data ready missing");

  a_ready_tail: assert property (
    clk_en && spi_mode_en && count_ff <= RDY_TAIL && !ovf_ff |=> !rdy_ff)
    else $error("data ready not dropped");

  a_ovf_drop: assert property (
    s_ovf |=> count_ff == '0 && ovf_ff && !hold_vld_ff ##1 (!clk_en || rdy_ff))
    else $error("overflow did not drop buffer");

  a_ovf_resume: assert property (
    ovf_ff ##0 s_restart |=> !ovf_ff && count_ff == 13'h0001)
    else $error("overflow not resolved by new packet");

  a_depth: assert property (
    count_ff <= BUF_FULL)
    else $error("fill level beyond depth");

  a_prefetch_fill: assert property (
    clk_en && rd_go ##1 clk_en && !ovf_now |=> hold_vld_ff)
    else $error("prefetch did not fill hold");

  a_mode_gate: assert property (
    !spi_sel_ff |-> !spi_mode_en && !mem_we && !link_on)
    else $error("spi path active without strap");

  a_hunt_drop: assert property (
    wr_st_ff == SSP_WR_HUNT && !ssp_is_start(wr_data) |-> !mem_we)
    else $error("byte stored while hunting for start");

  a_hunt_exit: assert property (
    s_restart |=> wr_st_ff == SSP_WR_PASS)
    else $error("start byte did not restart writer");

  a_read_pos_hold: assert property (
    clk_en && cs_n_s && !ovf_now |=> rd_ptr_ff == $past(rd_ptr_ff))
    else $error("read position moved while deselected");

endmodule : ssp_stream_port

/* bench/ssp_master_model.sv */
// spi mode 3 master model facing the stream port
// assumes 1 ns units; the bench calls one task at a time
`timescale 1ns/10ps
module ssp_master_model
  import ssp_pkg::*;
#(
  parameter int HALF_NS = 160
) (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = SCLK_IDLE;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // select, then a bit time before the first edge
  task automatic sel();
    cs_n = 1'b0;
    #(2 * HALF_NS);
  endtask : sel

  // only called once data ready is low
  task automatic desel();
    cs_n = 1'b1;
    #(2 * HALF_NS);
  endtask : desel

  // one character msb first, then a bit-time gap
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS - 10);
      rx[i] = miso;
      #(10);
    end
    mosi = ~mosi;
    #(2 * HALF_NS);
  endtask : xfer

  // bare clock pulses: stray or deselected edges
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
    end
  endtask : pulses
endmodule : ssp_master_model

/* bench/ssp_stream_port_bench.sv */
// self-checking bench of the spi stream port
// assumes the master model as far side; clk_en tied high
`timescale 1ns/10ps
module ssp_stream_port_bench
  import ssp_pkg::*;
;
  logic       clk;
  logic       nrst;
  logic       clk_en;
  logic       strap;
  logic       tp_en;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       data_ready_out;
  logic       spi_mode_en;
  logic       wr_valid;
  logic [7:0] wr_data;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       overflow_evt;
  int         bad_count;
  int         n_compared;
  int         ovf_cnt;
  int         rx_cnt;
  logic [7:0] exp_q [$];

  ssp_stream_port u_ssp_stream_port (
    .clk                        (clk),
    .nrst                       (nrst),
    .clk_en                     (clk_en),
    .shared_strap_timepulse_pin (strap),
    .timepulse_func_en          (tp_en),
    .sclk                       (sclk),
    .cs_n                       (cs_n),
    .mosi                       (mosi),
    .miso                       (miso),
    .data_ready_out             (data_ready_out),
    .spi_mode_en                (spi_mode_en),
    .wr_valid                   (wr_valid),
    .wr_data                    (wr_data),
    .rx_valid                   (rx_valid),
    .rx_data                    (rx_data),
    .overflow_evt               (overflow_evt)
  );

  ssp_master_model u_ssp_master_model (
    .sclk (sclk),
    .cs_n (cs_n),
    .mosi (mosi),
    .miso (miso)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx_valid === 1'b1) rx_cnt++;
  end

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic lvl);
    @(posedge clk);
    nrst  <= 1'b0;
    strap <= lvl;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset

  // one byte into the transmit buffer, overflow pulse counted
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data  <= d;
    @(negedge clk);
    if (overflow_evt === 1'b1) ovf_cnt++;
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask : wr

  task automatic send_pkt();
    foreach (exp_q[i]) wr(exp_q[i]);
  endtask : send_pkt

  // skip leading zeros, then match the queued packet
  task automatic read_pkt();
    logic [7:0] b;
    int         zeros;
    zeros = 0;
    #7;
    u_ssp_master_model.xfer(8'h00, b);
    while (b === ZERO_BYTE && zeros < 6) begin
      zeros++;
      u_ssp_master_model.xfer(8'h00, b);
    end
    chk(8'h01, {7'h00, zeros <= 4});
    foreach (exp_q[i]) begin
      if (i == exp_q.size() - 1) begin
        chk(8'h00, {7'h00, data_ready_out});
      end
      if (i > 0) begin
        u_ssp_master_model.xfer(8'h00, b);
      end
      chk(exp_q[i], b);
    end
  endtask : read_pkt

  task automatic t_mode();
    chk(8'h01, {7'h00, spi_mode_en});
    @(posedge clk);
    tp_en <= 1'b1;
    @(negedge clk);
    chk(8'h00, {7'h00, spi_mode_en});
    @(posedge clk);
    tp_en <= 1'b0;
    @(negedge clk);
    chk(8'h01, {7'h00, spi_mode_en});
  endtask : t_mode

  // stray bits, reselect, then a clean character
  task automatic t_resync();
    logic [7:0] b;
    int         c0;
    c0 = rx_cnt;
    #7;
    u_ssp_master_model.sel();
    u_ssp_master_model.pulses(3);
    u_ssp_master_model.desel();
    u_ssp_master_model.sel();
    u_ssp_master_model.xfer(8'h1d, b);
    chk(8'h1d, rx_data);
    chk(8'h01, 8'(rx_cnt - c0));
    chk(ZERO_BYTE, b);
    u_ssp_master_model.desel();
  endtask : t_resync

  task automatic t_packet();
    exp_q = '{START_BYTE, 8'h11, 8'h22, 8'h33, END_BYTE};
    #7;
    u_ssp_master_model.sel();
    send_pkt();
    repeat (3) @(posedge clk);
    chk(8'h01, {7'h00, data_ready_out});
    read_pkt();
    u_ssp_master_model.desel();
    chk(8'h00, {7'h00, data_ready_out});
  endtask : t_packet

  // clock edges while deselected move nothing
  task automatic t_idle_clock();
    exp_q = '{START_BYTE, 8'h5c, END_BYTE};
    send_pkt();
    #7;
    u_ssp_master_model.pulses(12);
    chk(8'h00, {7'h00, miso});
    u_ssp_master_model.sel();
    read_pkt();
    u_ssp_master_model.desel();
  endtask : t_idle_clock

  task automatic t_overflow();
    logic [7:0] b;
    ovf_cnt = 0;
    repeat (BUF_DEPTH) wr(8'h55);
    chk(8'h00, 8'(ovf_cnt));
    wr(8'h55);
    chk(8'h01, 8'(ovf_cnt));
    repeat (3) @(posedge clk);
    chk(8'h01, {7'h00, data_ready_out});
    #7;
    u_ssp_master_model.sel();
    repeat (2) begin
      u_ssp_master_model.xfer(8'h00, b);
      chk(ZERO_BYTE, b);
    end
    chk(8'h01, {7'h00, data_ready_out});
    wr(8'h12);
    exp_q = '{START_BYTE, 8'h34, END_BYTE};
    send_pkt();
    read_pkt();
    u_ssp_master_model.desel();
  endtask : t_overflow

  task automatic t_strap_off();
    do_reset(1'b1);
    chk(8'h00, {7'h00, spi_mode_en});
    exp_q = '{START_BYTE, 8'h01, END_BYTE};
    send_pkt();
    repeat (3) @(posedge clk);
    chk(8'h00, {7'h00, data_ready_out});
  endtask : t_strap_off

  initial begin
    nrst     <= 1'b0;
    clk_en   <= 1'b1;
    strap    <= 1'b0;
    tp_en    <= 1'b0;
    wr_valid <= 1'b0;
    wr_data  <= 8'h00;
    do_reset(1'b0);
    t_mode();
    t_resync();
    t_packet();
    t_idle_clock();
    t_overflow();
    t_strap_off();
    finish_test();
  end

  initial begin
    #(1_000_000);
    bad_count++;
    finish_test();
  end
endmodule : ssp_stream_port_bench
